// [rtl/rdm_module.sv]
// Registered DDR module end: input register, command decode,
// bank and power state, burst engines and a small word store.
// Runs on the link true clock; pins are source-synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_regs.svh"
module rdm_module
    import rdm_pkg::*;
(
    rdm_if.dev lk,
    input wire logic rst_b_in,
    output rdm_pwr_e power_state_out,
    output logic self_refresh_out,
    output logic [`RDM_BANKS-1:0] bank_open_out,
    output logic [`RDM_ADDR_W-1:0] mode_reg_out,
    output logic [`RDM_ADDR_W-1:0] ext_mode_reg_out
);
    localparam rdm_dev_s DEV_RST = '{pwr: RDM_PWR_PRE_PD, default: '0};
    rdm_dev_s q;
    rdm_dev_s d;
    logic clr_b;
    rdm_cmd_e cmd;
    logic exec;
    logic run;
    logic sr_live;
    logic [`RDM_LANES-1:0] lane_take;
    rdm_word_t pin_word;
    rdm_word_t wr_word;
    rdm_word_t old_word;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;

    // Either clear source empties every register except pwr, which loads precharge power-down
    assign clr_b = rst_b_in & lk.module_clear_b;
    // Chip select high masks the other three strobes
    assign cmd = q.c_cmd[3] ? RDM_CMD_DESEL : rdm_cmd_e'(q.c_cmd);
    assign run = (q.pwr == RDM_PWR_ACT) && q.c_cke;
    assign exec = run && q.c_ok;
    // Raising the gate ends self refresh without a clock edge
    assign sr_live = (q.pwr == RDM_PWR_SELF) && !lk.clock_gate_in;
    assign pin_word = {lk.ecc_check_lanes, lk.data_lanes};
    assign wr_idx = {q.wr_ba, q.wr_col};
    assign rd_idx = {q.rd_ba, q.rd_col};
    assign old_word = q.mem[wr_idx];

    for (genvar i = 0; i < `RDM_LANES; i++)
    begin : g_lane
        // A lane is taken when its strobe moved and its mask is low
        assign lane_take[i] = (lk.data_strobe_lanes[i] != q.dqs_prev[i])
            && !lk.write_mask_lanes[i];
        assign wr_word[8*i +: 8] = lane_take[i] ? pin_word[8*i +: 8] : old_word[8*i +: 8];
    end

    always_comb
    begin
        d = q;
        d.c_cke = lk.clock_gate_in;
        d.c_cke_prev = q.c_cke;
        d.dqs_prev = lk.data_strobe_lanes;
        // Pins other than the gate and data strobes are frozen outside the active state
        if (q.pwr == RDM_PWR_ACT)
        begin
            // Complement still high at the true rise marks the crossing
            d.c_ok = lk.diff_clk_comp;
            d.c_cmd = {lk.rank_sel_b, lk.row_strobe_b, lk.col_strobe_b,
                lk.write_strobe_b};
            d.c_ba = lk.bank_select;
            d.c_addr = lk.addr_lines;
        end

        unique case (q.pwr)
            RDM_PWR_ACT:
            begin
                if (!q.c_cke && q.c_cke_prev)
                begin
                    if (cmd == RDM_CMD_REF)
                        d.pwr = RDM_PWR_SELF;
                    else if (|q.open)
                        d.pwr = RDM_PWR_ACT_PD;
                    else
                        d.pwr = RDM_PWR_PRE_PD;
                end
            end
            RDM_PWR_PRE_PD, RDM_PWR_ACT_PD:
            begin
                if (q.c_cke)
                    d.pwr = RDM_PWR_ACT;
            end
            RDM_PWR_SELF:
            begin
                if (lk.clock_gate_in)
                    d.pwr = RDM_PWR_ACT;
            end
            default:
                d.pwr = RDM_PWR_PRE_PD;
        endcase

        if (exec)
        begin
            unique case (cmd)
                RDM_CMD_ACT:
                begin
                    d.open[q.c_ba] = 1'b1;
                    d.row[q.c_ba] = q.c_addr;
                end
                RDM_CMD_RD:
                begin
                    d.rd_pend = 1'b1;
                    d.rd_wait = rdm_rlat(q.mode[6:4]) - 3'h1;
                    d.rd_ba = q.c_ba;
                    d.rd_col = q.c_addr[`RDM_COL_W-1:0];
                    d.rd_ap = q.c_addr[`RDM_AP_BIT];
                end
                RDM_CMD_WR:
                begin
                    d.wr_act = 1'b1;
                    d.wr_left = rdm_beats(q.mode[2:0]);
                    d.wr_ba = q.c_ba;
                    d.wr_col = q.c_addr[`RDM_COL_W-1:0];
                    d.wr_ap = q.c_addr[`RDM_AP_BIT];
                end
                RDM_CMD_PRE:
                begin
                    if (q.c_addr[`RDM_AP_BIT])
                        d.open = '0;
                    else
                        d.open[q.c_ba] = 1'b0;
                end
                RDM_CMD_LMR:
                begin
                    if (q.c_ba == 2'h0)
                        d.mode = q.c_addr;
                    else if (q.c_ba == 2'h1)
                        d.emode = q.c_addr;
                end
                default:
                begin
                end
            endcase
        end

        // Burst engines stall whenever the internal clock is gated
        if (run && q.wr_act)
        begin
            d.mem[wr_idx] = wr_word;
            d.wr_col = q.wr_col + 4'h1;
            d.wr_left = q.wr_left - 4'h1;
            if (q.wr_left == 4'h1)
            begin
                d.wr_act = 1'b0;
                if (q.wr_ap)
                    d.open[q.wr_ba] = 1'b0;
            end
        end

        if (run && q.out_oe)
        begin
            if (q.rd_left == 4'h0)
            begin
                d.out_oe = 1'b0;
                if (q.rd_ap)
                    d.open[q.rd_ba] = 1'b0;
            end
            else
            begin
                d.dq = q.mem[rd_idx];
                d.dqs = ~q.dqs;
                d.rd_col = q.rd_col + 4'h1;
                d.rd_left = q.rd_left - 4'h1;
            end
        end
        else if (run && q.rd_pend)
        begin
            // Decode already sits one edge behind the pins
            if (q.rd_wait != 3'h0)
                d.rd_wait = q.rd_wait - 3'h1;
            else
            begin
                d.rd_pend = 1'b0;
                d.out_oe = 1'b1;
                d.dq = q.mem[rd_idx];
                d.dqs = ~q.dqs;
                d.rd_col = q.rd_col + 4'h1;
                d.rd_left = rdm_beats(q.mode[2:0]) - 4'h1;
            end
        end
    end

    always_ff @(posedge lk.diff_clk_true or negedge clr_b)
    begin
        if (!clr_b)
            q <= DEV_RST;
        else
            q <= d;
    end

    assign lk.dev_word = q.dq;
    // Gate low kills the drivers at once, not at the next edge
    assign lk.dev_dq_oe = q.out_oe & lk.clock_gate_in;
    assign lk.dev_dqs = {`RDM_LANES{q.dqs}};
    assign lk.dev_dqs_oe = q.out_oe & lk.clock_gate_in;
    assign power_state_out = q.pwr;
    assign self_refresh_out = sr_live;
    assign bank_open_out = q.open;
    assign mode_reg_out = q.mode;
    assign ext_mode_reg_out = q.emode;
endmodule
`default_nettype wire

// [rtl/rdm_regs.svh]
// Constants for the registered DDR module command port.
// Included by the package and by both ends; definitions only.
// Summary of operation
// - Clear low forces registered outputs low immediately; power_state_out loads precharge power-down instead
// - Controller may hold clear low at power-up
// - Strobes plus rank select form one command
// - Sample inputs where true rises, complement falls
// - Read data and strobe referenced to clock
// - Clock gate high enables, low disables device
// - Gate low enters precharge, self, or active power-down
// - Gate synchronous for power-down and self-refresh entry
// - Gate asynchronous for self-refresh exit, output disable
// - Controller holds gate high during every access; host forces it high only for write bursts
// - Power-down and self-refresh ignore other inputs
// - Rank select high masks every command
// - Bank select picks bank for commands
// - Address gives row, column, auto-precharge flag
// - Precharge flag picks one bank or all
// - Mode load: address opcode, bank picks register
// - Mask lane high blocks write, not read
// - Strobe edge-aligned on reads, centred on writes; host toggles it with the write data
// - Registered inputs add one cycle read latency
`ifndef RDM_REGS_SVH
`define RDM_REGS_SVH
`define RDM_ADDR_W 13
`define RDM_LANES 9
`define RDM_WORD_W 72
`define RDM_BANKS 4
`define RDM_COL_W 4
`define RDM_MEM_WORDS 64
`define RDM_AP_BIT 10
`define RDM_BL_CODE_2 3'h1
`define RDM_BL_CODE_4 3'h2
`define RDM_BL_CODE_8 3'h3
`define RDM_RLAT_CODE_3 3'h3
`define RDM_RLAT_CODE_25 3'h6
`define RDM_BEATS_2 4'h2
`define RDM_BEATS_4 4'h4
`define RDM_BEATS_8 4'h8
`define RDM_RLAT_2 3'h2
`define RDM_RLAT_3 3'h3
`define RDM_DIV_HALF 3'h4
`define RDM_FALL_CNT 3'h3
`define RDM_CLEAR_HOLD 4'hF
`endif

// [rtl/rdm_pkg.sv]
// Types shared by both ends of the module command port.
// Assumes rdm_regs.svh on the include path.
`default_nettype none
`include "rdm_regs.svh"
package rdm_pkg;
    typedef enum logic [3:0] {
        RDM_CMD_LMR = 4'h0, RDM_CMD_REF = 4'h1, RDM_CMD_PRE = 4'h2, RDM_CMD_ACT = 4'h3,
        RDM_CMD_WR = 4'h4, RDM_CMD_RD = 4'h5, RDM_CMD_BST = 4'h6, RDM_CMD_NOP = 4'h7,
        RDM_CMD_DESEL = 4'h8
    } rdm_cmd_e;
    typedef enum logic [3:0] {
        RDM_PWR_ACT = 4'h1, RDM_PWR_PRE_PD = 4'h2, RDM_PWR_ACT_PD = 4'h4, RDM_PWR_SELF = 4'h8
    } rdm_pwr_e;
    typedef enum logic [3:0] {
        RDM_H_CLEAR = 4'h1, RDM_H_IDLE = 4'h2, RDM_H_WGAP = 4'h4, RDM_H_WDATA = 4'h8
    } rdm_hst_e;
    typedef logic [`RDM_WORD_W-1:0] rdm_word_t;
    typedef struct packed {
        rdm_pwr_e pwr;
        logic c_cke;
        logic c_cke_prev;
        logic c_ok;
        logic [3:0] c_cmd;
        logic [1:0] c_ba;
        logic [`RDM_ADDR_W-1:0] c_addr;
        logic [`RDM_BANKS-1:0] open;
        logic [`RDM_BANKS-1:0][`RDM_ADDR_W-1:0] row;
        logic [`RDM_ADDR_W-1:0] mode;
        logic [`RDM_ADDR_W-1:0] emode;
        logic rd_pend;
        logic [2:0] rd_wait;
        logic [3:0] rd_left;
        logic [1:0] rd_ba;
        logic [`RDM_COL_W-1:0] rd_col;
        logic rd_ap;
        logic out_oe;
        rdm_word_t dq;
        logic dqs;
        logic wr_act;
        logic [3:0] wr_left;
        logic [1:0] wr_ba;
        logic [`RDM_COL_W-1:0] wr_col;
        logic wr_ap;
        logic [`RDM_LANES-1:0] dqs_prev;
        logic [`RDM_MEM_WORDS-1:0][`RDM_WORD_W-1:0] mem;
    } rdm_dev_s;
    typedef struct packed {
        rdm_hst_e st;
        logic [2:0] cnt;
        logic clk;
        logic comp;
        logic [3:0] clr_cnt;
        logic clear_b;
        logic cke;
        logic [3:0] cmd;
        logic [1:0] ba;
        logic [`RDM_ADDR_W-1:0] addr;
        logic [3:0] bl;
        logic [3:0] wr_left;
        logic drive;
        rdm_word_t dq;
        logic dqs;
        logic [`RDM_LANES-1:0] dm;
        logic dqs_last;
        rdm_word_t rd_q;
        logic rd_v;
    } rdm_hst_s;
    function automatic logic [3:0] rdm_beats(input logic [2:0] code);
        unique case (code)
            `RDM_BL_CODE_4: return `RDM_BEATS_4;
            `RDM_BL_CODE_8: return `RDM_BEATS_8;
            default: return `RDM_BEATS_2;
        endcase
    endfunction
    function automatic logic [2:0] rdm_rlat(input logic [2:0] code);
        // Half-cycle latency rounds up: one beat per clock here
        if (code == `RDM_RLAT_CODE_3 || code == `RDM_RLAT_CODE_25)
            return `RDM_RLAT_3;
        return `RDM_RLAT_2;
    endfunction
endpackage
`default_nettype wire

// [rtl/rdm_if.sv]
// Link between host controller and registered module.
// Two-way lanes resolve from the enables; nobody driving reads 0.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_regs.svh"
interface rdm_if;
    logic diff_clk_true;
    logic diff_clk_comp;
    logic module_clear_b;
    logic clock_gate_in;
    logic rank_sel_b;
    logic row_strobe_b;
    logic col_strobe_b;
    logic write_strobe_b;
    logic [1:0] bank_select;
    logic [`RDM_ADDR_W-1:0] addr_lines;
    logic [`RDM_LANES-1:0] write_mask_lanes;
    logic [`RDM_WORD_W-1:0] host_word;
    logic host_dq_oe;
    logic [`RDM_LANES-1:0] host_dqs;
    logic host_dqs_oe;
    logic [`RDM_WORD_W-1:0] dev_word;
    logic dev_dq_oe;
    logic [`RDM_LANES-1:0] dev_dqs;
    logic dev_dqs_oe;
    logic [`RDM_WORD_W-1:0] word;
    logic [63:0] data_lanes;
    logic [7:0] ecc_check_lanes;
    logic [`RDM_LANES-1:0] data_strobe_lanes;
    assign word = dev_dq_oe ? dev_word : (host_dq_oe ? host_word : '0);
    assign data_lanes = word[63:0];
    assign ecc_check_lanes = word[71:64];
    assign data_strobe_lanes = dev_dqs_oe ? dev_dqs : (host_dqs_oe ? host_dqs : '0);
    modport host (
        output diff_clk_true, diff_clk_comp, module_clear_b, clock_gate_in, rank_sel_b,
        output row_strobe_b, col_strobe_b, write_strobe_b, bank_select, addr_lines,
        output write_mask_lanes, host_word, host_dq_oe, host_dqs, host_dqs_oe,
        input data_lanes, ecc_check_lanes, data_strobe_lanes
    );
    modport dev (
        input diff_clk_true, diff_clk_comp, module_clear_b, clock_gate_in, rank_sel_b,
        input row_strobe_b, col_strobe_b, write_strobe_b, bank_select, addr_lines,
        input write_mask_lanes, data_lanes, ecc_check_lanes, data_strobe_lanes,
        output dev_word, dev_dq_oe, dev_dqs, dev_dqs_oe
    );
endinterface
`default_nettype wire

// [rtl/rdm_sync2.sv]
// Two-flop synchroniser for a bus of levels.
// Assumes each bit is stable for several destination cycles.
`timescale 1ns/1ps
`default_nettype none
module rdm_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [rtl/rdm_host.sv]
// Host controller end: divides its clock into the link clock,
// issues commands, drives write bursts and gathers read beats.
// Pins change at the link falling edge, mid-eye for the module.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_regs.svh"
module rdm_host
    import rdm_pkg::*;
(
    rdm_if.host lk,
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire rdm_cmd_e req_cmd_in,
    input wire logic [1:0] req_bank_in,
    input wire logic [`RDM_ADDR_W-1:0] req_addr_in,
    input wire logic power_down_in,
    input wire logic [`RDM_WORD_W-1:0] wdata_in,
    input wire logic [`RDM_LANES-1:0] wmask_in,
    output logic wdata_take_out,
    output logic [`RDM_WORD_W-1:0] rdata_out,
    output logic rdata_valid_out
);
    localparam rdm_hst_s HST_RST = '{st: RDM_H_CLEAR, cmd: RDM_CMD_NOP, clk: 1'b1,
        comp: 1'b0, default: '0};
    rdm_hst_s q;
    rdm_hst_s d;
    logic fall;
    logic [`RDM_WORD_W:0] rx_sync;

    rdm_sync2 #(
        .WIDTH(`RDM_WORD_W + 1)
    ) u_rx_sync (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .async_in({lk.data_strobe_lanes[0], lk.ecc_check_lanes, lk.data_lanes}),
        .sync_out(rx_sync)
    );

    assign fall = (q.cnt == `RDM_FALL_CNT);
    assign req_ready_out = fall && (q.st == RDM_H_IDLE);
    assign wdata_take_out = fall && (q.st == RDM_H_WDATA) && (q.wr_left != 4'h0);

    always_comb
    begin
        d = q;
        d.cnt = q.cnt + 3'h1;
        d.clk = (d.cnt < `RDM_DIV_HALF);
        // Complement trails so it is still high at the true rise
        d.comp = ~q.clk;
        d.rd_v = 1'b0;
        d.dqs_last = rx_sync[`RDM_WORD_W];
        // Strobe moved while the module drove: one read beat
        if (!q.drive && (rx_sync[`RDM_WORD_W] != q.dqs_last))
        begin
            d.rd_q = rx_sync[`RDM_WORD_W-1:0];
            d.rd_v = 1'b1;
        end
        if (fall)
        begin
            d.cmd = RDM_CMD_NOP;
            unique case (q.st)
                RDM_H_CLEAR:
                begin
                    // Clear held low keeps the gate and lanes quiet
                    d.clr_cnt = q.clr_cnt + 4'h1;
                    if (q.clr_cnt == `RDM_CLEAR_HOLD)
                    begin
                        d.clear_b = 1'b1;
                        d.st = RDM_H_IDLE;
                    end
                end
                RDM_H_IDLE:
                begin
                    // Gate moves only in idle, so never during a write burst
                    d.cke = ~power_down_in;
                    if (req_valid_in)
                    begin
                        d.cmd = req_cmd_in;
                        d.ba = req_bank_in;
                        d.addr = req_addr_in;
                        if (req_cmd_in == RDM_CMD_LMR && req_bank_in == 2'h0)
                            d.bl = rdm_beats(req_addr_in[2:0]);
                        if (req_cmd_in == RDM_CMD_WR)
                        begin
                            d.cke = 1'b1;
                            d.wr_left = q.bl;
                            d.st = RDM_H_WGAP;
                        end
                    end
                end
                RDM_H_WGAP:
                    d.st = RDM_H_WDATA;
                RDM_H_WDATA:
                begin
                    if (q.wr_left == 4'h0)
                    begin
                        d.drive = 1'b0;
                        d.st = RDM_H_IDLE;
                    end
                    else
                    begin
                        d.drive = 1'b1;
                        d.dq = wdata_in;
                        d.dm = wmask_in;
                        d.dqs = ~q.dqs;
                        d.wr_left = q.wr_left - 4'h1;
                    end
                end
                default:
                    d.st = RDM_H_CLEAR;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            q <= HST_RST;
        else
            q <= d;
    end

    assign lk.diff_clk_true = q.clk;
    assign lk.diff_clk_comp = q.comp;
    assign lk.module_clear_b = q.clear_b;
    assign lk.clock_gate_in = q.cke;
    assign lk.rank_sel_b = q.cmd[3];
    assign lk.row_strobe_b = q.cmd[2];
    assign lk.col_strobe_b = q.cmd[1];
    assign lk.write_strobe_b = q.cmd[0];
    assign lk.bank_select = q.ba;
    assign lk.addr_lines = q.addr;
    assign lk.write_mask_lanes = q.dm;
    assign lk.host_word = q.dq;
    assign lk.host_dq_oe = q.drive;
    assign lk.host_dqs = {`RDM_LANES{q.dqs}};
    assign lk.host_dqs_oe = q.drive;
    assign rdata_out = q.rd_q;
    assign rdata_valid_out = q.rd_v;
endmodule
`default_nettype wire

// [sim/rdm_props.sv]
// Checker for the link between host controller and registered module.
// Assumes burst length 2, read latency 2 and single reads from the bench.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_regs.svh"
module rdm_props (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic diff_clk_true,
    input wire logic diff_clk_comp,
    input wire logic module_clear_b,
    input wire logic clock_gate_in,
    input wire logic rank_sel_b,
    input wire logic row_strobe_b,
    input wire logic col_strobe_b,
    input wire logic write_strobe_b,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic [`RDM_LANES-1:0] dev_dqs,
    input wire logic dev_dqs_oe
);
    a_clear_quiets_lanes: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !module_clear_b |-> !dev_dq_oe && !dev_dqs_oe)
        else $error("module drives lanes during clear");
    a_clear_holds_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !module_clear_b |-> !clock_gate_in)
        else $error("clock gate high during clear");
    a_gate_low_quiet: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !clock_gate_in |-> !dev_dq_oe && !dev_dqs_oe)
        else $error("module drives lanes with gate low");
    a_single_driver: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !(dev_dq_oe && host_dq_oe))
        else $error("both ends drive the data lanes");
    a_gate_during_write: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        host_dq_oe |-> clock_gate_in)
        else $error("gate low during write burst");
    a_read_latency: assert property (@(posedge diff_clk_true)
        disable iff (!rst_b_in || !module_clear_b)
        !rank_sel_b && row_strobe_b && !col_strobe_b && write_strobe_b && diff_clk_comp
        && clock_gate_in |-> ##3 !dev_dq_oe ##1 dev_dq_oe)
        else $error("read data not at registered latency");
    a_read_burst_shape: assert property (@(posedge diff_clk_true)
        disable iff (!rst_b_in || !module_clear_b)
        $rose(dev_dqs_oe) |-> dev_dqs[0] ##1 (dev_dqs_oe && !dev_dqs[0]) ##1 !dev_dqs_oe)
        else $error("read strobe burst malformed");
    a_lanes_lockstep: assert property (@(posedge diff_clk_true)
        disable iff (!rst_b_in || !module_clear_b)
        dev_dqs_oe |-> dev_dqs == {`RDM_LANES{dev_dqs[0]}})
        else $error("strobe lanes out of step");
    a_deselect_ignored: assert property (@(posedge diff_clk_true)
        disable iff (!rst_b_in || !module_clear_b)
        rank_sel_b && !dev_dq_oe |-> ##1 !dev_dq_oe [*4])
        else $error("deselected command answered");
endmodule
`default_nettype wire

// [sim/tb_registered_ddr_module_command_port.sv]
// Bench joining host and module ends through the link interface.
// Assumes the host divides clock_in to make the link clock.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_regs.svh"
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb_registered_ddr_module_command_port
    import rdm_pkg::*;
;
    localparam rdm_word_t D0 = 72'hA5_1122334455667788;
    localparam rdm_word_t D1 = 72'h3C_99AABBCCDDEEFF00;
    logic clock_in;
    logic rst_b_in;
    logic req_valid_in;
    logic req_ready_out;
    rdm_cmd_e req_cmd_in;
    logic [1:0] req_bank_in;
    logic [`RDM_ADDR_W-1:0] req_addr_in;
    logic power_down_in;
    rdm_word_t wdata_in;
    logic [`RDM_LANES-1:0] wmask_in;
    logic wdata_take_out;
    rdm_word_t rdata_out;
    logic rdata_valid_out;
    rdm_pwr_e power_state_out;
    logic self_refresh_out;
    logic [`RDM_BANKS-1:0] bank_open_out;
    logic [`RDM_ADDR_W-1:0] mode_reg_out;
    logic [`RDM_ADDR_W-1:0] ext_mode_reg_out;
    int num_errors;
    int tests_run;
    rdm_word_t rq[$];
    rdm_if lk();
    rdm_host rdm_host_inst (.lk(lk), .clock_in(clock_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_cmd_in(req_cmd_in),
        .req_bank_in(req_bank_in), .req_addr_in(req_addr_in), .power_down_in(power_down_in),
        .wdata_in(wdata_in), .wmask_in(wmask_in), .wdata_take_out(wdata_take_out),
        .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out));
    rdm_module rdm_module_inst (.lk(lk), .rst_b_in(rst_b_in),
        .power_state_out(power_state_out), .self_refresh_out(self_refresh_out),
        .bank_open_out(bank_open_out),
        .mode_reg_out(mode_reg_out), .ext_mode_reg_out(ext_mode_reg_out));
    rdm_props rdm_props_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .diff_clk_true(lk.diff_clk_true), .diff_clk_comp(lk.diff_clk_comp),
        .module_clear_b(lk.module_clear_b), .clock_gate_in(lk.clock_gate_in),
        .rank_sel_b(lk.rank_sel_b), .row_strobe_b(lk.row_strobe_b),
        .col_strobe_b(lk.col_strobe_b), .write_strobe_b(lk.write_strobe_b),
        .host_dq_oe(lk.host_dq_oe), .dev_dq_oe(lk.dev_dq_oe), .dev_dqs(lk.dev_dqs),
        .dev_dqs_oe(lk.dev_dqs_oe));
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    // Read beats are single-cycle pulses, so gather them as they come
    always @(posedge clock_in)
    begin
        if (rdata_valid_out === 1'b1)
            rq.push_back(rdata_out);
    end
    task automatic link_wait(input int n);
        repeat (8 * n) @(posedge clock_in);
    endtask
    // Wait on the falling edge so ready is settled before the taking edge
    task automatic wait_high(ref logic sig);
        int i;
        i = 0;
        do
        begin
            @(negedge clock_in);
            i++;
        end
        while (sig !== 1'b1 && i < 400);
        @(posedge clock_in);
    endtask
    task automatic req(input rdm_cmd_e cmd, input logic [1:0] bank, input logic [12:0] addr);
        @(posedge clock_in);
        req_valid_in <= 1'b1;
        req_cmd_in <= cmd;
        req_bank_in <= bank;
        req_addr_in <= addr;
        wait_high(req_ready_out);
        req_valid_in <= 1'b0;
    endtask
    task automatic wr(input logic [1:0] bank, input logic [12:0] addr, input logic [8:0] m0);
        @(posedge clock_in);
        wdata_in <= D0;
        wmask_in <= m0;
        req(RDM_CMD_WR, bank, addr);
        wait_high(wdata_take_out);
        wdata_in <= D1;
        wmask_in <= 9'h000;
        wait_high(wdata_take_out);
    endtask
    task automatic rd(input logic [1:0] bank, input logic [12:0] addr, input rdm_word_t e0,
                      input rdm_word_t e1);
        int i;
        rq.delete();
        req(RDM_CMD_RD, bank, addr);
        for (i = 0; i < 400 && rq.size() < 2; i++)
            @(posedge clock_in);
        `CHK(rq.size(), 2)
        `CHK(rq[0], e0)
        `CHK(rq[1], e1)
    endtask
    task automatic results();
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clock_in);
        num_errors++;
        results();
    end
    initial
    begin
        rst_b_in = 1'b0;
        req_valid_in = 1'b0;
        req_cmd_in = RDM_CMD_NOP;
        req_bank_in = 2'h0;
        req_addr_in = 13'h0000;
        power_down_in = 1'b0;
        wdata_in = '0;
        wmask_in = 9'h000;
        num_errors = 0;
        tests_run = 0;
        repeat (16) @(posedge clock_in);
        `CHK(power_state_out, RDM_PWR_PRE_PD)
        `CHK(lk.dev_dq_oe, 1'b0)
        rst_b_in <= 1'b1;
        // Module ignores pins until the clear ends and the gate has woken it
        link_wait(22);
        `CHK(power_state_out, RDM_PWR_ACT)
        req(RDM_CMD_LMR, 2'h0, 13'h0021);
        req(RDM_CMD_LMR, 2'h1, 13'h0040);
        link_wait(4);
        `CHK(power_state_out, RDM_PWR_ACT)
        `CHK(mode_reg_out, 13'h0021)
        `CHK(ext_mode_reg_out, 13'h0040)
        req(RDM_CMD_ACT, 2'h1, 13'h0155);
        link_wait(4);
        `CHK(bank_open_out, 4'h2)
        // First beat has lane 0 masked, so that byte keeps its cleared value
        wr(2'h1, 13'h0003, 9'h001);
        rd(2'h1, 13'h0403, {D0[71:8], 8'h00}, D1);
        link_wait(4);
        `CHK(bank_open_out, 4'h0)
        // Strobes of a deselect spell a mode load to bank 0 if rank is ignored
        req(RDM_CMD_DESEL, 2'h0, 13'h0155);
        link_wait(4);
        `CHK(bank_open_out, 4'h0)
        `CHK(mode_reg_out, 13'h0021)
        req(RDM_CMD_ACT, 2'h0, 13'h0011);
        req(RDM_CMD_ACT, 2'h2, 13'h0022);
        req(RDM_CMD_PRE, 2'h0, 13'h0000);
        link_wait(4);
        `CHK(bank_open_out, 4'h4)
        power_down_in <= 1'b1;
        link_wait(6);
        `CHK(power_state_out, RDM_PWR_ACT_PD)
        power_down_in <= 1'b0;
        link_wait(6);
        `CHK(power_state_out, RDM_PWR_ACT)
        req(RDM_CMD_PRE, 2'h1, 13'h0400);
        link_wait(4);
        `CHK(bank_open_out, 4'h0)
        power_down_in <= 1'b1;
        link_wait(6);
        `CHK(power_state_out, RDM_PWR_PRE_PD)
        power_down_in <= 1'b0;
        link_wait(6);
        `CHK(power_state_out, RDM_PWR_ACT)
        power_down_in <= 1'b1;
        req(RDM_CMD_REF, 2'h0, 13'h0000);
        link_wait(4);
        `CHK(power_state_out, RDM_PWR_SELF)
        `CHK(self_refresh_out, 1'b1)
        power_down_in <= 1'b0;
        link_wait(4);
        `CHK(self_refresh_out, 1'b0)
        `CHK(power_state_out, RDM_PWR_ACT)
        rst_b_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        `CHK(power_state_out, RDM_PWR_PRE_PD)
        `CHK(mode_reg_out, 13'h0000)
        rst_b_in <= 1'b1;
        link_wait(2);
        results();
    end
endmodule
`default_nettype wire
